// [bench/tet_host_model.sv]
`default_nettype none

module tet_host_model #(
    parameter int DELAY = 4
) (
    input  wire logic i_clk,
    input  wire logic i_on,
    input  wire logic i_pin,
    output logic      o_status_read
);
    timeunit 1ns;
    timeprecision 100ps;

    int cnt = 0;
    initial o_status_read = 1'b0;

    // Slow host: reads status only after the pin has stood DELAY cycles
    always @(posedge i_clk) begin
        cnt = (i_on && i_pin && cnt < DELAY) ? cnt + 1 : 0;
        o_status_read <= #1 (cnt == DELAY);
    end
endmodule

`default_nettype wire

// [bench/tet_trigger_cfg_chk.sv]
`default_nettype none

module tet_trigger_cfg_chk (
    input wire logic                 I_MCLK,
    input wire logic                 I_RST,
    input wire logic                 I_REG_WR,
    input wire logic [7:0]           I_REG_ADDR,
    input wire logic [7:0]           I_REG_WDATA,
    input wire logic                 I_STATUS_READ,
    input wire tet_pkg::tet_events_t I_EVENTS,
    input wire logic                 I_SAMPLE_PUSH,
    input wire logic                 I_CAL_POINTS_DONE,
    input wire logic                 O_NV_WR,
    input wire logic [7:0]           O_NV_DATA,
    input wire logic                 O_PENDING_ACTIVITY_OUT,
    input wire logic                 O_CAL_ACTIVE,
    input wire logic                 O_CAL_ABORT,
    input wire logic                 O_SAMPLE_QUEUE_ENABLE,
    input wire logic                 O_FIFO_FLUSH,
    input wire logic [4:0]           O_FIFO_COUNT,
    input wire logic                 O_QUEUE_THRESHOLD_FLAG
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking @(posedge I_MCLK); endclocking
    default disable iff (I_RST);

    wire logic trig_wr = I_REG_WR && I_REG_ADDR == 8'h00;
    wire logic fifo_wr = I_REG_WR && I_REG_ADDR == 8'h01;

    ////////////////////////////////////////////////////////////////////////////
    nv_image_a: assert property (trig_wr |=> O_NV_WR &&
        O_NV_DATA == ($past(I_REG_WDATA) & 8'hbf)) else $error("stored image wrong");
    cal_start_a: assert property (trig_wr && I_REG_WDATA[6] |=> O_CAL_ACTIVE)
        else $error("calibration did not start");
    cal_abort_a: assert property (O_CAL_ACTIVE && trig_wr && !I_REG_WDATA[6]
        |=> O_CAL_ABORT && !O_CAL_ACTIVE) else $error("calibration not aborted");
    cal_done_a: assert property (O_CAL_ACTIVE && I_CAL_POINTS_DONE && !trig_wr
        |=> !O_CAL_ACTIVE) else $error("calibration did not end");
    fifo_flush_a: assert property (fifo_wr |=> O_FIFO_FLUSH && O_FIFO_COUNT == 5'h00)
        else $error("setup write did not flush");
    push_gate_a: assert property (I_SAMPLE_PUSH && !O_SAMPLE_QUEUE_ENABLE
        |=> O_FIFO_COUNT <= $past(O_FIFO_COUNT)) else $error("sample stored while off");
    full_flag_a: assert property (O_FIFO_COUNT == 5'h10 |=> O_QUEUE_THRESHOLD_FLAG)
        else $error("full queue not flagged");
    empty_flag_a: assert property (O_FIFO_COUNT == 5'h00 |=> !O_QUEUE_THRESHOLD_FLAG)
        else $error("empty queue flagged");
    // Events in the cycle after the read may re-pend, so only two cycles out
    read_clear_a: assert property (I_STATUS_READ && I_EVENTS == 7'h00 &&
        !O_QUEUE_THRESHOLD_FLAG |-> ##2 !O_PENDING_ACTIVITY_OUT) else $error("pin not cleared");
endmodule

bind tet_trigger_cfg tet_trigger_cfg_chk i_chk (.I_MCLK, .I_RST, .I_REG_WR, .I_REG_ADDR,
    .I_REG_WDATA, .I_STATUS_READ, .I_EVENTS, .I_SAMPLE_PUSH, .I_CAL_POINTS_DONE, .O_NV_WR,
    .O_NV_DATA, .O_PENDING_ACTIVITY_OUT, .O_CAL_ACTIVE, .O_CAL_ABORT, .O_SAMPLE_QUEUE_ENABLE,
    .O_FIFO_FLUSH, .O_FIFO_COUNT, .O_QUEUE_THRESHOLD_FLAG);

`default_nettype wire

// [bench/tet_trigger_cfg_tb.sv]
`default_nettype none

module tet_trigger_cfg_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int MS = 4;
    logic clk = 0, rst = 1, wr = 0, rd = 0, cdone = 0, pres = 0, load = 0;
    logic push = 0, pop = 0, host_on = 0, sread, nvwr, pin, cact, cabort, qen, flush, flag, tick;
    logic [7:0] addr = 8'h00, wdata = 8'h00, nvin = 8'h00, rdata, nvd, pms;
    logic [4:0] cnt;
    tet_pkg::tet_events_t ev = 7'h00;
    int mismatches = 0, checks_done = 0, n;
    int evb[7] = '{6, 5, 4, 3, 2, 1, 0};
    int trb[7] = '{7, 5, 4, 3, 1, 0, 0};

    always #50 clk = ~clk;

    tet_trigger_cfg #(.MS_CYCLES(MS)) i_dut (.I_MCLK(clk), .I_RST(rst), .I_REG_WR(wr),
        .I_REG_RD(rd), .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
        .I_STATUS_READ(sread), .I_EVENTS(ev), .I_SAMPLE_PUSH(push), .I_SAMPLE_POP(pop),
        .I_CAL_POINTS_DONE(cdone), .I_PRESSURE_MEASURE_ENABLE(pres), .I_NV_LOAD(load),
        .I_NV_DATA(nvin), .O_NV_WR(nvwr), .O_NV_DATA(nvd), .O_PENDING_ACTIVITY_OUT(pin),
        .O_CAL_ACTIVE(cact), .O_CAL_ABORT(cabort), .O_SAMPLE_QUEUE_ENABLE(qen),
        .O_FIFO_FLUSH(flush), .O_FIFO_COUNT(cnt), .O_QUEUE_THRESHOLD_FLAG(flag),
        .O_SAMPLING_PERIOD_MS(pms), .O_SAMPLE_TICK(tick));

    tet_host_model i_host (.i_clk(clk), .i_on(host_on), .i_pin(pin), .o_status_read(sread));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        // Idle edge first, so back-to-back calls never merge into one long strobe
        step(1);
        addr = a;
        wdata = d;
        wr = 1;
        step(1);
        wr = 0;
    endtask

    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        step(1);
        addr = a;
        rd = 1;
        step(1);
        rd = 0;
        chk("rdata", rdata, exp);
    endtask

    task automatic pushn(input int k);
        push = 1;
        step(k);
        push = 0;
    endtask

    task give_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        step(4);
        rst = 0;
        step(1);
        rreg(8'h00, 8'h00);
        rreg(8'h01, 8'h00);
        rreg(8'h02, 8'h0a);
        rreg(8'h03, 8'h00);
        chk("period", pms, 8'h0a);
        $display("test defaults done");

        // Each event first against all other enables except watermark and calibration, then its own
        host_on = 1;
        for (int i = 0; i < 7; i++) begin
            for (int on = 0; on < 2; on++) begin
                wreg(8'h00, on == 1 ? 8'(1 << trb[i]) : 8'hbb & ~8'(1 << trb[i]));
                ev = tet_pkg::tet_events_t'(7'(1 << evb[i]));
                step(1);
                ev = 7'h00;
                step(1);
                chk("pin", 8'(pin), 8'(on));
            end
            step(8);
            chk("pin", 8'(pin), 8'h00);
        end
        host_on = 0;
        $display("test events done");

        wreg(8'h00, 8'h40);
        chk("cal", 8'(cact), 8'h01);
        chk("nv", nvd, 8'h00);
        chk("nvwr", 8'(nvwr), 8'h01);
        rreg(8'h00, 8'h40);
        wreg(8'h00, 8'h00);
        chk("abort", 8'(cabort), 8'h01);
        chk("cal", 8'(cact), 8'h00);
        wreg(8'h00, 8'h40);
        cdone = 1;
        step(1);
        cdone = 0;
        chk("cal", 8'(cact), 8'h00);
        wreg(8'h00, 8'h40);
        rst = 1;
        step(1);
        rst = 0;
        step(1);
        chk("cal", 8'(cact), 8'h00);
        load = 1;
        nvin = 8'hff;
        step(1);
        load = 0;
        rreg(8'h00, 8'hbf);
        $display("test calibration done");

        wreg(8'h00, 8'h04);
        wreg(8'h01, 8'h13);
        chk("qen", 8'(qen), 8'h01);
        pushn(2);
        step(1);
        chk("flag", 8'(flag), 8'h00);
        pushn(1);
        chk("count", 8'(cnt), 8'h03);
        step(1);
        chk("flag", 8'(flag), 8'h01);
        step(2);
        chk("pin", 8'(pin), 8'h01);
        pop = 1;
        step(1);
        pop = 0;
        chk("count", 8'(cnt), 8'h02);
        rreg(8'h01, 8'h13);
        wreg(8'h01, 8'hf0);
        chk("count", 8'(cnt), 8'h00);
        rreg(8'h01, 8'h10);
        pushn(15);
        step(1);
        chk("flag", 8'(flag), 8'h00);
        pushn(2);
        chk("count", 8'(cnt), 8'h10);
        step(1);
        chk("flag", 8'(flag), 8'h01);
        pres = 1;
        step(1);
        chk("flush", 8'(flush), 8'h01);
        step(1);
        chk("count", 8'(cnt), 8'h00);
        wreg(8'h01, 8'h03);
        pushn(2);
        chk("count", 8'(cnt), 8'h00);
        wreg(8'h00, 8'h00);
        $display("test fifo done");

        wreg(8'h02, 8'h05);
        step(1);
        chk("period", pms, 8'h05);
        n = 0;
        while (tick !== 1'b1 && n < 1000) begin
            step(1);
            n++;
        end
        n = 1;
        step(1);
        while (tick !== 1'b1 && n < 1000) begin
            step(1);
            n++;
        end
        chk("interval", 8'(n), 8'(5 * MS));
        wreg(8'h02, 8'h03);
        rreg(8'h02, 8'h03);
        chk("period", pms, 8'h05);
        wreg(8'h02, 8'hc8);
        step(1);
        chk("period", pms, 8'h64);
        $display("test period done");
        give_verdict;
    end

    // Whole run is a few hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        give_verdict;
    end
endmodule

`default_nettype wire

// [hw/tet_defs.svh]
`ifndef TET_DEFS_SVH
`define TET_DEFS_SVH

// Register offsets on the serial register port
`define TET_REG_TRIG        8'h00
`define TET_REG_FIFO        8'h01
`define TET_REG_PERIOD      8'h02

// Event trigger enable bit positions
`define TET_TRIG_REL        7
`define TET_TRIG_CAL        6
`define TET_TRIG_PINCH      5
`define TET_TRIG_ROT        4
`define TET_TRIG_SLD        3
`define TET_TRIG_WM         2
`define TET_TRIG_CAP        1
`define TET_TRIG_SMP        0
`define TET_TRIG_RST        8'h00
`define TET_TRIG_NV_MASK    8'hbf

// FIFO setup fields
`define TET_FIFO_EN_BIT     4
`define TET_FIFO_WM_MSB     3
`define TET_FIFO_WM_LSB     0
`define TET_FIFO_RST        8'h00
`define TET_FIFO_RW_MASK    8'h1f
`define TET_WM_OFF          4'h0

// Sample counter
`define TET_CNT_W           5
`define TET_FIFO_DEPTH      5'h10
`define TET_CNT_ZERO        5'h00
`define TET_CNT_ONE         5'h01

// Sampling period, milliseconds
`define TET_PERIOD_RST      8'h0a
`define TET_PERIOD_MIN      8'h05
`define TET_PERIOD_MAX      8'h64
`define TET_PERIOD_ONE      8'h01

// Clock and the millisecond tick
`define TET_CLK_HZ          10000000
`define TET_TICK_MS         1
`define TET_MS_PER_S        1000

`endif

// [hw/tet_pkg.sv]
`default_nettype none

package tet_pkg;

    // One-cycle event pulses from the scanning and gesture logic
    typedef struct packed {
        logic release_evt;
        logic pinch_evt;
        logic rotate_evt;
        logic slide_evt;
        logic cap_evt;
        logic sample_done_evt;
        logic resistive_evt;
    } tet_events_t;

    typedef enum logic [1:0] {
        TET_CAL_IDLE = 2'b00,
        TET_CAL_RUN  = 2'b01
    } tet_cal_state_t;

endpackage

`default_nettype wire

// [hw/tet_sample_count.sv]
`default_nettype none
`include "tet_defs.svh"

module tet_sample_count (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_push,
    input  wire logic                  i_pop,
    input  wire logic                  i_flush,
    output logic [`TET_CNT_W-1:0]      o_count,
    output logic                       o_full
);

    logic                  push_ok;
    logic                  pop_ok;
    logic [`TET_CNT_W-1:0] next_count;

    assign o_full  = (o_count == `TET_FIFO_DEPTH);
    // Samples arriving while full are dropped, not wrapped
    assign push_ok = i_push & ~o_full;
    assign pop_ok  = i_pop & (o_count != `TET_CNT_ZERO);

    always_comb begin
        next_count = o_count;
        if (i_flush) begin
            next_count = `TET_CNT_ZERO;
        end else if (push_ok & ~pop_ok) begin
            next_count = o_count + `TET_CNT_ONE;
        end else if (pop_ok & ~push_ok) begin
            next_count = o_count - `TET_CNT_ONE;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_count <= `TET_CNT_ZERO;
        end else begin
            o_count <= next_count;
        end
    end

endmodule

`default_nettype wire

// [hw/tet_trigger_cfg.sv]
`default_nettype none
`include "tet_defs.svh"

module tet_trigger_cfg #(
    parameter int MS_CYCLES = `TET_CLK_HZ / `TET_MS_PER_S * `TET_TICK_MS
) (
    input  wire logic                I_MCLK,
    input  wire logic                I_RST,
    input  wire logic                I_REG_WR,
    input  wire logic                I_REG_RD,
    input  wire logic [7:0]          I_REG_ADDR,
    input  wire logic [7:0]          I_REG_WDATA,
    output logic      [7:0]          O_REG_RDATA,
    input  wire logic                I_STATUS_READ,
    input  wire tet_pkg::tet_events_t I_EVENTS,
    input  wire logic                I_SAMPLE_PUSH,
    input  wire logic                I_SAMPLE_POP,
    input  wire logic                I_CAL_POINTS_DONE,
    input  wire logic                I_PRESSURE_MEASURE_ENABLE,
    input  wire logic                I_NV_LOAD,
    input  wire logic [7:0]          I_NV_DATA,
    output logic                     O_NV_WR,
    output logic      [7:0]          O_NV_DATA,
    output logic                     O_PENDING_ACTIVITY_OUT,
    output logic                     O_CAL_ACTIVE,
    output logic                     O_CAL_ABORT,
    output logic                     O_SAMPLE_QUEUE_ENABLE,
    output logic                     O_FIFO_FLUSH,
    output logic      [4:0]          O_FIFO_COUNT,
    output logic                     O_QUEUE_THRESHOLD_FLAG,
    output logic      [7:0]          O_SAMPLING_PERIOD_MS,
    output logic                     O_SAMPLE_TICK
);

    localparam int MSW = $clog2(MS_CYCLES + 1);

    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
        reg_hit = (addr == off);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register decode

    logic       trig_wr;
    logic       fifo_wr;
    logic       period_wr;
    logic [7:0] trig;
    logic [7:0] fifo_setup;
    logic [7:0] period;
    logic [7:0] rd_data;

    assign trig_wr   = I_REG_WR & reg_hit(I_REG_ADDR, `TET_REG_TRIG);
    assign fifo_wr   = I_REG_WR & reg_hit(I_REG_ADDR, `TET_REG_FIFO);
    assign period_wr = I_REG_WR & reg_hit(I_REG_ADDR, `TET_REG_PERIOD);

    ////////////////////////////////////////////////////////////////////////////
    // Event trigger enables

    logic release_trigger_en;
    logic pinch_trigger_en;
    logic rotate_trigger_en;
    logic slide_trigger_en;
    logic watermark_trigger_en;
    logic cap_event_trigger_en;
    logic sample_event_trigger_en;
    logic [7:0] next_trig;

    assign release_trigger_en      = trig[`TET_TRIG_REL];
    assign pinch_trigger_en        = trig[`TET_TRIG_PINCH];
    assign rotate_trigger_en       = trig[`TET_TRIG_ROT];
    assign slide_trigger_en        = trig[`TET_TRIG_SLD];
    assign watermark_trigger_en    = trig[`TET_TRIG_WM];
    assign cap_event_trigger_en    = trig[`TET_TRIG_CAP];
    assign sample_event_trigger_en = trig[`TET_TRIG_SMP];

    // Calibration start never lands in the stored image
    always_comb begin
        next_trig = trig;
        if (trig_wr) begin
            next_trig = I_REG_WDATA & `TET_TRIG_NV_MASK;
        end else if (I_NV_LOAD) begin
            next_trig = I_NV_DATA & `TET_TRIG_NV_MASK;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            trig      <= `TET_TRIG_RST;
            O_NV_WR   <= 1'b0;
            O_NV_DATA <= `TET_TRIG_RST;
        end else begin
            trig      <= next_trig;
            O_NV_WR   <= trig_wr;
            O_NV_DATA <= I_REG_WDATA & `TET_TRIG_NV_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Calibration control

    tet_pkg::tet_cal_state_t cal_state;
    tet_pkg::tet_cal_state_t next_cal_state;
    logic                    cal_bit_wr;
    logic                    next_abort;

    assign cal_bit_wr = I_REG_WDATA[`TET_TRIG_CAL];

    always_comb begin
        next_cal_state = cal_state;
        next_abort     = 1'b0;
        case (cal_state)
            tet_pkg::TET_CAL_IDLE: begin
                if (trig_wr & cal_bit_wr) begin
                    next_cal_state = tet_pkg::TET_CAL_RUN;
                end
            end
            tet_pkg::TET_CAL_RUN: begin
                if (trig_wr & ~cal_bit_wr) begin
                    next_cal_state = tet_pkg::TET_CAL_IDLE;
                    next_abort     = 1'b1;
                end else if (I_CAL_POINTS_DONE & ~trig_wr) begin
                    next_cal_state = tet_pkg::TET_CAL_IDLE;
                end
            end
            default: begin
                next_cal_state = tet_pkg::TET_CAL_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            cal_state    <= tet_pkg::TET_CAL_IDLE;
            O_CAL_ACTIVE <= 1'b0;
            O_CAL_ABORT  <= 1'b0;
        end else begin
            cal_state    <= next_cal_state;
            O_CAL_ACTIVE <= (next_cal_state == tet_pkg::TET_CAL_RUN);
            O_CAL_ABORT  <= next_abort;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // FIFO setup, flush and fill level

    logic                  sample_queue_enable;
    logic [3:0]            sample_queue_threshold;
    logic                  press_q;
    logic                  press_changed;
    logic                  flush_now;
    logic                  fifo_full;
    logic                  next_flag;
    logic [`TET_CNT_W-1:0] count;

    assign sample_queue_enable    = fifo_setup[`TET_FIFO_EN_BIT];
    assign sample_queue_threshold = fifo_setup[`TET_FIFO_WM_MSB:`TET_FIFO_WM_LSB];
    assign press_changed          = I_PRESSURE_MEASURE_ENABLE ^ press_q;
    // Keeps X, Y and pressure buffers in step
    assign flush_now = fifo_wr | (sample_queue_enable & press_changed);

    tet_sample_count u_count (
        .i_clk   (I_MCLK),
        .i_rst   (I_RST),
        .i_push  (I_SAMPLE_PUSH & sample_queue_enable),
        .i_pop   (I_SAMPLE_POP),
        .i_flush (flush_now),
        .o_count (count),
        .o_full  (fifo_full)
    );

    assign O_FIFO_COUNT = count;

    // Flag follows the current count, one cycle behind it
    assign next_flag = (sample_queue_threshold == `TET_WM_OFF) ? fifo_full
                     : (count >= {1'b0, sample_queue_threshold});

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            fifo_setup             <= `TET_FIFO_RST;
            press_q                <= 1'b0;
            O_FIFO_FLUSH           <= 1'b0;
            O_SAMPLE_QUEUE_ENABLE  <= 1'b0;
            O_QUEUE_THRESHOLD_FLAG <= 1'b0;
        end else begin
            if (fifo_wr) begin
                fifo_setup <= I_REG_WDATA & `TET_FIFO_RW_MASK;
            end
            press_q                <= I_PRESSURE_MEASURE_ENABLE;
            O_FIFO_FLUSH           <= flush_now;
            O_SAMPLE_QUEUE_ENABLE  <= fifo_wr ? I_REG_WDATA[`TET_FIFO_EN_BIT]
                                              : sample_queue_enable;
            O_QUEUE_THRESHOLD_FLAG <= next_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pending events and the pending-activity pin

    logic [7:0] evt_vec;
    logic [7:0] pending;
    logic [7:0] enabled_pending;

    assign evt_vec[`TET_TRIG_REL]   = I_EVENTS.release_evt;
    assign evt_vec[`TET_TRIG_CAL]   = 1'b0;
    assign evt_vec[`TET_TRIG_PINCH] = I_EVENTS.pinch_evt;
    assign evt_vec[`TET_TRIG_ROT]   = I_EVENTS.rotate_evt;
    assign evt_vec[`TET_TRIG_SLD]   = I_EVENTS.slide_evt;
    // Level, so a read cannot hide a still-reached watermark
    assign evt_vec[`TET_TRIG_WM]    = O_QUEUE_THRESHOLD_FLAG;
    assign evt_vec[`TET_TRIG_CAP]   = I_EVENTS.cap_evt;
    assign evt_vec[`TET_TRIG_SMP]   = I_EVENTS.sample_done_evt | I_EVENTS.resistive_evt;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pend
            logic pend;
            // Set beats the status-read clear in the same cycle
            always_ff @(posedge I_MCLK) begin
                if (I_RST) begin
                    pend <= 1'b0;
                end else if (evt_vec[gi] & trig[gi]) begin
                    pend <= 1'b1;
                end else if (I_STATUS_READ) begin
                    pend <= 1'b0;
                end
            end
            // One flop per bit keeps each process the sole writer
            assign pending[gi] = pend;
        end
    endgenerate

    // Clearing an enable drops its pending share at once
    assign enabled_pending = pending & trig;

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            O_PENDING_ACTIVITY_OUT <= 1'b0;
        end else begin
            O_PENDING_ACTIVITY_OUT <= |enabled_pending;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sampling period and tick

    logic [7:0]     period_eff;
    logic [MSW-1:0] ms_cnt;
    logic [7:0]     per_cnt;
    logic           ms_tick;
    logic           per_done;

    // Out-of-range values are clamped rather than trusted
    assign period_eff = (period < `TET_PERIOD_MIN) ? `TET_PERIOD_MIN
                      : (period > `TET_PERIOD_MAX) ? `TET_PERIOD_MAX : period;
    assign ms_tick  = (ms_cnt == MSW'(MS_CYCLES - 1));
    assign per_done = ms_tick & (per_cnt >= period_eff - `TET_PERIOD_ONE);

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            period               <= `TET_PERIOD_RST;
            ms_cnt               <= '0;
            per_cnt              <= 8'h00;
            O_SAMPLING_PERIOD_MS <= `TET_PERIOD_RST;
            O_SAMPLE_TICK        <= 1'b0;
        end else begin
            if (period_wr) begin
                period <= I_REG_WDATA;
            end
            ms_cnt               <= ms_tick ? '0 : ms_cnt + MSW'(1);
            if (per_done | period_wr) begin
                per_cnt <= 8'h00;
            end else if (ms_tick) begin
                per_cnt <= per_cnt + `TET_PERIOD_ONE;
            end
            O_SAMPLING_PERIOD_MS <= period_eff;
            O_SAMPLE_TICK        <= per_done & ~period_wr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read-back

    assign rd_data = reg_hit(I_REG_ADDR, `TET_REG_TRIG)
                         ? {trig[`TET_TRIG_REL], (cal_state == tet_pkg::TET_CAL_RUN),
                            trig[`TET_TRIG_PINCH:`TET_TRIG_SMP]}
                   : reg_hit(I_REG_ADDR, `TET_REG_FIFO)   ? fifo_setup
                   : reg_hit(I_REG_ADDR, `TET_REG_PERIOD) ? period
                   : 8'h00;

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            O_REG_RDATA <= 8'h00;
        end else if (I_REG_RD) begin
            O_REG_RDATA <= rd_data;
        end
    end

endmodule

`default_nettype wire
